// File: inc/mrasp_pkg.sv
// Constants, types and helpers shared by the multirange converter serial port
package mrasp_pkg;

    // Configuration byte layout, most significant bit first
    localparam int unsigned CFG_BITS      = 8;
    localparam int unsigned CFG_START_POS = 7;
    localparam int unsigned CFG_CH_HI     = 6;
    localparam int unsigned CFG_CH_LO     = 4;
    localparam int unsigned CFG_DIF_POS   = 3;
    localparam int unsigned CFG_RANGE_HI  = 2;
    localparam int unsigned CFG_RANGE_LO  = 0;

    // Widths and counts
    localparam int unsigned CH_W          = 3;
    localparam int unsigned RANGE_W       = 3;
    localparam int unsigned RESULT_BITS   = 14;
    localparam int unsigned CNT_W         = 4;
    localparam int unsigned NUM_CH_LARGE  = 8;
    localparam int unsigned NUM_CH_SMALL  = 4;
    localparam int unsigned SE_RANGES     = 7;
    localparam int unsigned DIF_RANGES    = 3;

    // Reset values
    localparam logic [RANGE_W-1:0]     RANGE_RST  = 3'h7;
    localparam logic                   DIF_RST    = 1'b0;
    localparam logic [RESULT_BITS-1:0] RESULT_RST = 14'h0000;

    // Counter constants at counter width
    localparam logic [CNT_W-1:0] CNT_ZERO      = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE       = 4'h1;
    localparam logic [CNT_W-1:0] CNT_CFG_LAST  = 4'h7;
    localparam logic [CNT_W-1:0] CNT_RES_LAST  = 4'hd;

    // Serial port sequencer states
    typedef enum logic [1:0] {
        MRASP_IDLE,
        MRASP_HUNT,
        MRASP_CFG,
        MRASP_DATA
    } mrasp_state_t;

    // A range code is legal if it is one of the seven single-ended or three differential codes
    function automatic logic range_ok(input logic dif, input logic [RANGE_W-1:0] code);
        logic [RANGE_W:0] lim;
        lim = dif ? (RANGE_W+1)'(DIF_RANGES) : (RANGE_W+1)'(SE_RANGES);
        range_ok = (code != '0) && ({1'b0, code} <= lim);
    endfunction

endpackage

// File: inc/mrasp_cfg_if.sv
// Link between the serial port sequencer and the per-channel configuration store
`timescale 1ns/100ps
interface mrasp_cfg_if;
    logic                             wr_en;
    logic [mrasp_pkg::CH_W-1:0]       wr_ch;
    logic                             wr_dif;
    logic [mrasp_pkg::RANGE_W-1:0]    wr_range;
    logic                             wr_taken;

    modport port (output wr_en, output wr_ch, output wr_dif, output wr_range, input wr_taken);
    modport store (input wr_en, input wr_ch, input wr_dif, input wr_range, output wr_taken);
endinterface

// File: hw/mrasp_cfg_store.sv
// Per-channel configuration store: input mode and range for every analog channel
`timescale 1ns/100ps
module mrasp_cfg_store #(
    parameter int unsigned NUM_CH = mrasp_pkg::NUM_CH_LARGE
) (
    input  wire logic                              core_clk_i,
    input  wire logic                              rst_i,
    mrasp_cfg_if.store                             cfg,
    input  wire logic [mrasp_pkg::CH_W-1:0]        rd_ch_i,
    output logic                                   rd_dif_o,
    output logic [mrasp_pkg::RANGE_W-1:0]          rd_range_o
);

    logic                           dif_reg   [NUM_CH];
    logic [mrasp_pkg::RANGE_W-1:0]  range_reg [NUM_CH];
    logic                           accept;

    // Writes to a channel the variant lacks, or with an illegal range, are dropped
    assign accept       = cfg.wr_en && (32'(cfg.wr_ch) < NUM_CH)
                          && mrasp_pkg::range_ok(cfg.wr_dif, cfg.wr_range);
    assign cfg.wr_taken = accept;

    // One independent setting per channel
    always_ff @(posedge core_clk_i)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (rst_i)
            begin
                dif_reg[i]   <= mrasp_pkg::DIF_RST;
                range_reg[i] <= mrasp_pkg::RANGE_RST;
            end
            else if (accept && (32'(cfg.wr_ch) == i))
            begin
                dif_reg[i]   <= cfg.wr_dif; // 0 single-ended, 1 differential
                range_reg[i] <= cfg.wr_range;
            end
        end
    end

    // Registered readback of the channel being converted
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rd_dif_o   <= mrasp_pkg::DIF_RST;
            rd_range_o <= mrasp_pkg::RANGE_RST;
        end
        else if (32'(rd_ch_i) < NUM_CH)
        begin
            rd_dif_o   <= dif_reg[rd_ch_i];
            rd_range_o <= range_reg[rd_ch_i];
        end
        else
        begin
            rd_dif_o   <= mrasp_pkg::DIF_RST;
            rd_range_o <= mrasp_pkg::RANGE_RST;
        end
    end

endmodule

// File: hw/mrasp_serial_port.sv
// Serial host port of the multichannel 14-bit converter: config byte in, results out, ready strobe
//
// Functional notes
// - With chip select low, serial input is sampled on each rising shift clock edge.
// - With chip select low, serial output changes on each falling shift clock edge.
// - With chip select high, shift clock and serial input are ignored entirely.
// - With chip select high, serial output is released to high impedance.
// - In internal-clock mode the ready strobe rises when a result is ready.
// - In external-clock mode the ready strobe stays low.
// - The ready strobe is always driven, whatever chip select does.
// - Large variant has eight inputs (four pairs), small has four (two pairs).
// - Each channel keeps its own mode and one of seven or three ranges.
// - Each conversion result is a 14-bit successive-approximation value.
// - First logic one after chip select falls is the config byte start bit.
// - Config bits six to four pick the channel being configured.
// - Config bit three: zero single-ended, one differential for that channel.
`timescale 1ns/100ps
module mrasp_serial_port #(
    parameter int unsigned NUM_CH = mrasp_pkg::NUM_CH_LARGE
) (
    input  wire logic                                core_clk_i,
    input  wire logic                                rst_i,
    input  wire logic                                cs_n_i,
    input  wire logic                                sclk_i,
    input  wire logic                                din_i,
    output logic                                     dout_o,
    output logic                                     dout_oe_n_o,
    output logic                                     data_ready_strobe_o,
    input  wire logic                                int_clk_mode_i,
    input  wire logic [mrasp_pkg::RESULT_BITS-1:0]   result_i,
    input  wire logic                                result_valid_i,
    output logic                                     cfg_apply_o,
    output logic [mrasp_pkg::CH_W-1:0]               conv_ch_o,
    output logic                                     conv_dif_o,
    output logic [mrasp_pkg::RANGE_W-1:0]            conv_range_o
);

    // Pin synchronisers: first stage feeds only the second
    logic        cs_n_s1_reg;
    logic        cs_n_s2_reg;
    logic        sclk_s1_reg;
    logic        sclk_s2_reg;
    logic        din_s1_reg;
    logic        din_s2_reg;
    logic        sclk_d_reg;

    logic        sel;
    logic        sclk_rise;
    logic        sclk_fall;

    mrasp_pkg::mrasp_state_t state_reg;
    mrasp_pkg::mrasp_state_t state_next;

    logic [mrasp_pkg::CFG_BITS-1:0]    cfg_sh_reg;
    logic [mrasp_pkg::CFG_BITS-1:0]    cfg_sh_next;
    logic [mrasp_pkg::CNT_W-1:0]       bit_cnt_reg;
    logic [mrasp_pkg::RESULT_BITS-1:0] result_reg;
    logic [mrasp_pkg::RESULT_BITS-1:0] out_sh_reg;
    logic                              dout_reg;
    logic                              cfg_done;
    logic                              strobe_reg;
    logic [mrasp_pkg::CH_W-1:0]        conv_ch_reg;
    logic                              apply_reg;

    mrasp_cfg_if cfg_link ();

    // Two-stage synchronisers on every pin from the host
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            din_s1_reg  <= 1'b0;
            din_s2_reg  <= 1'b0;
        end
        else
        begin
            cs_n_s1_reg <= cs_n_i;
            cs_n_s2_reg <= cs_n_s1_reg;
            sclk_s1_reg <= sclk_i;
            sclk_s2_reg <= sclk_s1_reg;
            din_s1_reg  <= din_i;
            din_s2_reg  <= din_s1_reg;
        end
    end

    // Edge finder on the synchronised shift clock
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            sclk_d_reg <= 1'b0;
        else
            sclk_d_reg <= sclk_s2_reg;
    end

    // Edges only count while selected; otherwise the clock is ignored
    assign sel       = !cs_n_s2_reg;
    assign sclk_rise = sel && sclk_s2_reg && !sclk_d_reg;
    assign sclk_fall = sel && !sclk_s2_reg && sclk_d_reg;

    // Config byte is complete on the eighth rising edge counted from the start bit
    assign cfg_done    = (state_reg == mrasp_pkg::MRASP_CFG) && sclk_rise
                         && (bit_cnt_reg == mrasp_pkg::CNT_CFG_LAST);
    assign cfg_sh_next = {cfg_sh_reg[mrasp_pkg::CFG_BITS-2:0], din_s2_reg}; // MSB first

    // Next-state logic of the port sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            mrasp_pkg::MRASP_IDLE:
                if (sel)
                    state_next = mrasp_pkg::MRASP_HUNT;
            mrasp_pkg::MRASP_HUNT:
                if (!sel)
                    state_next = mrasp_pkg::MRASP_IDLE;
                else if (sclk_rise && din_s2_reg)
                    state_next = mrasp_pkg::MRASP_CFG; // First one is the start bit
            mrasp_pkg::MRASP_CFG:
                if (!sel)
                    state_next = mrasp_pkg::MRASP_IDLE;
                else if (cfg_done)
                    state_next = mrasp_pkg::MRASP_DATA;
            mrasp_pkg::MRASP_DATA:
                if (!sel)
                    state_next = mrasp_pkg::MRASP_IDLE;
            default:
                state_next = mrasp_pkg::MRASP_IDLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            state_reg <= mrasp_pkg::MRASP_IDLE;
        else
            state_reg <= state_next;
    end

    // Config shifter and bit counter, loaded by the start bit
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cfg_sh_reg  <= '0;
            bit_cnt_reg <= mrasp_pkg::CNT_ZERO;
        end
        else if (state_reg == mrasp_pkg::MRASP_HUNT && sclk_rise && din_s2_reg)
        begin
            cfg_sh_reg  <= cfg_sh_next;            // Start bit lands at bit 0, ends at bit 7
            bit_cnt_reg <= mrasp_pkg::CNT_ONE;
        end
        else if (state_reg == mrasp_pkg::MRASP_CFG && sclk_rise)
        begin
            cfg_sh_reg  <= cfg_sh_next;            // Sample on rising edge
            bit_cnt_reg <= bit_cnt_reg + mrasp_pkg::CNT_ONE;
        end
        else if (state_reg == mrasp_pkg::MRASP_DATA && sclk_fall)
        begin
            if (bit_cnt_reg != mrasp_pkg::CNT_RES_LAST)
                bit_cnt_reg <= bit_cnt_reg + mrasp_pkg::CNT_ONE;
        end
        else if (state_reg == mrasp_pkg::MRASP_IDLE)
            bit_cnt_reg <= mrasp_pkg::CNT_ZERO;
    end

    // Write the finished byte into the per-channel store
    assign cfg_link.wr_en    = cfg_done;
    assign cfg_link.wr_ch    = cfg_sh_next[mrasp_pkg::CFG_CH_HI:mrasp_pkg::CFG_CH_LO];
    assign cfg_link.wr_dif   = cfg_sh_next[mrasp_pkg::CFG_DIF_POS];
    assign cfg_link.wr_range = cfg_sh_next[mrasp_pkg::CFG_RANGE_HI:mrasp_pkg::CFG_RANGE_LO];

    // Channel for the next conversion follows the last accepted byte
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            conv_ch_reg <= '0;
            apply_reg   <= 1'b0;
        end
        else
        begin
            apply_reg <= cfg_link.wr_taken;
            if (cfg_link.wr_taken)
                conv_ch_reg <= cfg_link.wr_ch;
        end
    end

    // Latest 14-bit conversion result from the converter core
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            result_reg <= mrasp_pkg::RESULT_RST;
        else if (result_valid_i)
            result_reg <= result_i;
    end

    // Result shifter: loaded at the end of the config byte, MSB out on falling edges
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            out_sh_reg <= mrasp_pkg::RESULT_RST;
            dout_reg   <= 1'b0;
        end
        else if (cfg_done)
        begin
            out_sh_reg <= result_reg;
            dout_reg   <= 1'b0;
        end
        else if (state_reg == mrasp_pkg::MRASP_DATA && sclk_fall)
        begin
            dout_reg   <= out_sh_reg[mrasp_pkg::RESULT_BITS-1];
            out_sh_reg <= {out_sh_reg[mrasp_pkg::RESULT_BITS-2:0], 1'b0};
        end
        else if (!sel)
            dout_reg <= 1'b0;
    end

    // Output driver enabled only while selected
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            dout_oe_n_o <= 1'b1;
        else
            dout_oe_n_o <= cs_n_s2_reg;         // Released when deselected
    end

    assign dout_o = dout_reg;

    // Ready strobe: set by a new result, cleared when the host selects the port
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            strobe_reg <= 1'b0;
        else if (!int_clk_mode_i)
            strobe_reg <= 1'b0;                 // Held low in external-clock mode
        else if (result_valid_i)
            strobe_reg <= 1'b1;                 // Set wins over the clear
        else if (sel)
            strobe_reg <= 1'b0;
    end

    assign data_ready_strobe_o = strobe_reg;    // Always driven, never released

    // Channel store, sized by variant
    mrasp_cfg_store #(
        .NUM_CH (NUM_CH)
    ) u_store (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .cfg        (cfg_link.store),
        .rd_ch_i    (conv_ch_reg),
        .rd_dif_o   (conv_dif_o),
        .rd_range_o (conv_range_o)
    );

    assign cfg_apply_o = apply_reg;
    assign conv_ch_o   = conv_ch_reg;

endmodule

// File: bench/mrasp_serial_port_sva.sv
// Concurrent checks on the serial port pins and converter-side outputs
`timescale 1ns/100ps
module mrasp_serial_port_sva #(
    parameter int unsigned NUM_CH = mrasp_pkg::NUM_CH_LARGE
) (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        cs_n_i,
    input  wire logic                        dout_oe_n_o,
    input  wire logic                        data_ready_strobe_o,
    input  wire logic                        int_clk_mode_i,
    input  wire logic                        result_valid_i,
    input  wire logic                        cfg_apply_o,
    input  wire logic [mrasp_pkg::CH_W-1:0]  conv_ch_o,
    input  wire logic                        conv_dif_o,
    input  wire logic [mrasp_pkg::RANGE_W-1:0] conv_range_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Output enable follows the select pin through the synchroniser
    AST_OE_OFF: assert property (cs_n_i [*4] |-> dout_oe_n_o)
        else $error("dout driven while deselected");
    AST_OE_ON: assert property (!cs_n_i [*4] |-> !dout_oe_n_o)
        else $error("dout not driven while selected");
    // Config bytes only land inside a selected frame, as single pulses
    AST_APPLY_SEL: assert property (cfg_apply_o |-> !$past(cs_n_i, 3))
        else $error("config applied without select");
    AST_APPLY_PULSE: assert property (cfg_apply_o |=> !cfg_apply_o)
        else $error("config apply longer than one cycle");
    AST_CH_LEGAL: assert property (cfg_apply_o |-> 32'(conv_ch_o) < NUM_CH)
        else $error("applied channel out of range");
    AST_RANGE: assert property (cfg_apply_o |=> conv_range_o != 3'h0 && (!conv_dif_o || conv_range_o <= 3'h3))
        else $error("applied range code illegal");
    // Ready strobe set, cause, forced low and hold while deselected
    AST_STB_SET: assert property (int_clk_mode_i && result_valid_i |=> data_ready_strobe_o)
        else $error("strobe missed a result");
    AST_STB_CAUSE: assert property ($rose(data_ready_strobe_o) |->
        $past(result_valid_i) && $past(int_clk_mode_i))
        else $error("strobe rose without a result");
    AST_STB_EXT: assert property (!int_clk_mode_i |=> !data_ready_strobe_o)
        else $error("strobe high in external clock mode");
    AST_STB_HOLD: assert property ((cs_n_i && int_clk_mode_i) [*4] ##0 data_ready_strobe_o |=>
        data_ready_strobe_o)
        else $error("strobe dropped while deselected");

    // Main scenarios reached
    COV_APPLY: cover property (cfg_apply_o);
    COV_STB: cover property ($rose(data_ready_strobe_o));
    COV_OE: cover property ($fell(dout_oe_n_o));
endmodule

bind mrasp_serial_port mrasp_serial_port_sva #(.NUM_CH(NUM_CH)) u_mrasp_serial_port_sva (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .dout_oe_n_o(dout_oe_n_o),
    .data_ready_strobe_o(data_ready_strobe_o), .int_clk_mode_i(int_clk_mode_i),
    .result_valid_i(result_valid_i), .cfg_apply_o(cfg_apply_o), .conv_ch_o(conv_ch_o),
    .conv_dif_o(conv_dif_o), .conv_range_o(conv_range_o));

// File: bench/mrasp_host_model.sv
// Host model: serial bus master driving select, shift clock and data
`timescale 1ns/100ps
module mrasp_host_model (
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      din_o,
    input  wire logic dout_i
);
    // Idle: deselected, clock low
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o  = 1'b0;
    end

    // One frame: leading zeros, config byte, then result clocks sampled before each fall
    task automatic frame(input logic [7:0] c, input int lead, input int n, output logic [13:0] got);
        int j;
        got    = '0;
        cs_n_o = 1'b0;
        #1200;
        for (int i = 0; i < lead + n; i++)
        begin
            j     = i - lead;
            din_o = (j < 0) ? 1'b0 : (j < 8) ? c[7 - j] : ~din_o;
            #400 sclk_o = 1'b1;
            #400;
            if (j >= 8)
                got = {got[12:0], dout_i};
            sclk_o = 1'b0;
        end
        #1200 cs_n_o = 1'b1;
        din_o = ~din_o; // Released data line keeps moving
        #1200;
    endtask

    // Clock and data activity with select high
    task automatic noise();
        repeat (6)
        begin
            #400 sclk_o = ~sclk_o;
            din_o = ~din_o;
        end
    endtask

    // Select level alone, no clocks
    task automatic sel(input logic v);
        cs_n_o = v;
    endtask
endmodule

// File: bench/multirange_adc_serial_port_bench.sv
// Self-checking bench for the converter serial port with a host bus model
`timescale 1ns/100ps
module multirange_adc_serial_port_bench;
    logic        core_clk_i = 1'b0;
    logic        rst_i      = 1'b1;
    logic        icm        = 1'b0;
    logic        rv         = 1'b0;
    logic [13:0] res        = 14'h0000;
    logic        cs_n, sclk, din, dout, oe_n, stb, apply, dif;
    logic [2:0]  ch, rng;
    logic [2:0]  lch        = 3'h0;
    logic [2:0]  lrng       = 3'h7;
    logic        ldif       = 1'b0;
    logic [3:0]  tab [8]    = '{4'h1, 4'hb, 4'h7, 4'h9, 4'h4, 4'ha, 4'h6, 4'hb};
    int          error_cnt  = 0;
    int          checked    = 0;
    int          cyc        = 0;
    int          napply     = 0;
    int          base;
    wire         dout_w     = oe_n ? 1'bz : dout;

    mrasp_serial_port #(.NUM_CH(mrasp_pkg::NUM_CH_LARGE)) u_mrasp_serial_port (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout),
        .dout_oe_n_o(oe_n), .data_ready_strobe_o(stb), .int_clk_mode_i(icm), .result_i(res),
        .result_valid_i(rv), .cfg_apply_o(apply), .conv_ch_o(ch), .conv_dif_o(dif), .conv_range_o(rng));
    mrasp_host_model u_mrasp_host_model (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout_w));

    // Core clock, 100 ns period
    initial
        forever #50 core_clk_i = ~core_clk_i;

    // Counts config applies on settled outputs and cuts a hang short
    always @(negedge core_clk_i)
    begin
        cyc <= cyc + 1;
        if (apply === 1'b1)
            napply <= napply + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One-cycle result pulse from the converter core
    task automatic load(input logic [13:0] v);
        @(negedge core_clk_i);
        res = v;
        rv  = 1'b1;
        @(negedge core_clk_i);
        rv  = 1'b0;
    endtask

    // Full frame, then stored settings and shifted result against expectations
    task automatic xfer(input logic [7:0] c, input int lead, input int n, input logic ok);
        logic [13:0] got;
        int          a;
        a = napply;
        u_mrasp_host_model.frame(c, lead, n, got);
        if (ok)
        begin
            {lch, ldif, lrng} = c[6:0];
            chk("result", res, got);
        end
        chk("applies", {13'h0, ok}, 14'(napply - a));
        chk("channel", {11'h0, lch}, {11'h0, ch});
        chk("mode", {13'h0, ldif}, {13'h0, dif});
        chk("range", {11'h0, lrng}, {11'h0, rng});
        chk("oe_n", 14'h1, {13'h0, oe_n});
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        chk("range", 14'h7, {11'h0, rng});
        chk("stb", 14'h0, {13'h0, stb});
        for (int i = 0; i < 8; i++)
        begin
            load(14'h2a5c ^ 14'(i * 1811));
            xfer({1'b1, 3'(i), tab[i]}, i % 3, 22, 1'b1);
        end
        xfer(8'ha0, 0, 22, 1'b0);
        xfer(8'hbd, 1, 22, 1'b0);
        xfer(8'hcb, 0, 5, 1'b0);
        load(14'h3c01);
        xfer(8'hcb, 0, 22, 1'b1);
        base = napply;
        u_mrasp_host_model.noise();
        repeat (8) @(negedge core_clk_i);
        chk("applies", 14'h0, 14'(napply - base));
        chk("oe_n", 14'h1, {13'h0, oe_n});
        icm = 1'b1;
        load(14'h1234);
        chk("stb", 14'h1, {13'h0, stb});
        repeat (10) @(negedge core_clk_i);
        chk("stb", 14'h1, {13'h0, stb});
        u_mrasp_host_model.sel(1'b0);
        repeat (6) @(negedge core_clk_i);
        chk("stb", 14'h0, {13'h0, stb});
        u_mrasp_host_model.sel(1'b1);
        repeat (6) @(negedge core_clk_i);
        load(14'h0fed);
        icm = 1'b0;
        @(negedge core_clk_i);
        chk("stb", 14'h0, {13'h0, stb});
        load(14'h3fff);
        chk("stb", 14'h0, {13'h0, stb});
        finish_test();
    end
endmodule
